// ==== logic/dpram_host_consts.vh ====
`ifndef DPRAM_HOST_CONSTS_VH
`define DPRAM_HOST_CONSTS_VH
// Purpose : Constants for the host-side port controller of a dual-port SRAM.
// Assumes : System clock of 10 MHz (100 ns period).
// Notes   : Times are in ns; cycle counts derive from them.
`define CLK_PERIOD_NS      100
`define T_RC_NS            25
`define T_PWE_NS           22
`define T_HZWE_NS          15
`define T_SD_NS            15
`define T_SOP_NS           12
`define T_SWRD_NS          5
`define T_WH_NS            17
`define T_BDD_NS           25
`define T_AA_NS            25
`define CEIL_CYC(t)        ((((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
                            (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define PWR_WAIT_CYC       (`CEIL_CYC(`T_RC_NS) + 1)
`define WR_PULSE_CYC       `CEIL_CYC(`T_HZWE_NS + `T_SD_NS)
`define SOP_CYC            `CEIL_CYC(`T_SOP_NS)
`define WH_CYC             `CEIL_CYC(`T_WH_NS)
`define RD_WAIT_CYC        `CEIL_CYC(`T_AA_NS + `T_BDD_NS)
`define SEM_ADDR_BITS      3
`endif

// ==== logic/cycle_timer.v ====
// Purpose : Down counter that pulses done when a loaded count expires.
// Assumes : Single clock, synchronous active-high reset.
// Notes   : A load of N gives done N cycles after the load.
module cycle_timer #(
    parameter WIDTH = 4
) (
    // Clock and reset.
    input  wire             sys_clk,
    input  wire             reset,
    // Control.
    input  wire             load,
    input  wire [WIDTH-1:0] count,
    // Status.
    output wire             done
);
    reg [WIDTH-1:0] cnt_q;

    // ==========================================================
    // Counter
    // The counter holds at zero between loads.
    always @(posedge sys_clk) begin
        if (reset) begin
            cnt_q <= {WIDTH{1'b0}};
        end else if (load) begin
            cnt_q <= count;
        end else if (cnt_q != {WIDTH{1'b0}}) begin
            cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    assign done = (cnt_q == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule // cycle_timer

// ==== logic/dpram_port_host.v ====
// Purpose : Host controller that drives one port of an asynchronous dual-port SRAM.
// Assumes : 10 MHz sys_clk; each SRAM timing is met by whole clock cycles.
// Notes   : Handles array reads/writes and semaphore take/release/read.
//
// Summary of operation
// R01 - Array uses chip select low, semaphore select high; semaphore the reverse; held steady.
// R02 - Read-not-write stays high throughout every read.
// R03 - Read-not-write is high whenever the address changes.
// R04 - Device writes only while a select and read-not-write overlap low.
// R05 - Write ends at first rising select or read-not-write; address held past it.
// R06 - With output enable low during a write, pulse covers driver turn-off plus setup.
// R07 - Select falling with or after read-not-write keeps device outputs off.
// R08 - Address is valid before or as the select falls on a read.
// R09 - Semaphore reads always use a fresh select-driven cycle.
// R10 - After a semaphore write, select stays high the flag update pulse.
// R11 - Updated semaphore flag is readable no sooner than 5 ns after write end.
// R12 - Simultaneous semaphore requests are granted to exactly one port.
// R13 - Semaphores start free at the beginning of a contention cycle.
// R14 - Slave writer holds read-not-write high a while after contention flag rises.
// R15 - Read data is valid a bounded delay after contention flag release.
// R16 - During retention both port chip selects stay inactive high; an access already running when retain rises still finishes with its select low.
// R17 - After power-up wait longer than one read cycle before any access.
// R18 - Device sets or clears the mailbox interrupt within its set or reset time.
// R19 - Semaphore address uses only the three lowest address lines.
// R20 - Writing zero to a free semaphore grants it; only the owner changes it.
// R21 - Semaphore read drives the latched value on every data line.
// R22 - Contention flag is an input in slave mode, an output in master mode.
// R23 - Device behaviour is edge-to-edge pin delays with no clock or reset.
`include "dpram_host_consts.vh"
module dpram_port_host #(
    parameter ADDR_W = 17,
    parameter DATA_W = 9
) (
    // Clock and reset.
    input  wire              sys_clk,
    input  wire              reset,
    // User request side.
    input  wire              req_valid,
    input  wire              req_write,
    input  wire              req_sem,
    input  wire [ADDR_W-1:0] req_addr,
    input  wire [DATA_W-1:0] req_wdata,
    input  wire              retain,
    output reg               req_ready,
    output reg               rsp_valid,
    output reg  [DATA_W-1:0] rsp_rdata,
    // Memory port pins.
    output reg               chip_select_n,
    output reg               semaphore_select_n,
    output reg               read_write_n,
    output reg               output_enable_n,
    output reg               upper_byte_enable_n,
    output reg  [ADDR_W-1:0] addr,
    output reg  [DATA_W-1:0] data_out,
    output reg               data_oe,
    input  wire [DATA_W-1:0] data_in,
    input  wire              busy_n
);
    // State codes.
    localparam [2:0] ST_PWRUP = 3'h0;
    localparam [2:0] ST_IDLE  = 3'h1;
    localparam [2:0] ST_SETUP = 3'h2;
    localparam [2:0] ST_RD    = 3'h3;
    localparam [2:0] ST_WR    = 3'h4;
    localparam [2:0] ST_WEND  = 3'h5;
    localparam [2:0] ST_GAP   = 3'h6;

    localparam integer PWR_CYC_I = `PWR_WAIT_CYC;
    localparam integer WR_CYC_I  = `WR_PULSE_CYC;
    localparam integer SOP_CYC_I = `SOP_CYC;
    localparam integer WH_CYC_I  = `WH_CYC;
    // Two extra cycles cover the read-data synchroniser ahead of the sample.
    localparam integer RD_CYC_I  = `RD_WAIT_CYC + 2;

    localparam [3:0] PWR_CYC = PWR_CYC_I[3:0];
    localparam [3:0] WR_CYC  = WR_CYC_I[3:0];
    localparam [3:0] SOP_CYC = SOP_CYC_I[3:0];
    localparam [3:0] WH_CYC  = WH_CYC_I[3:0];
    localparam [3:0] RD_CYC  = RD_CYC_I[3:0];

    reg  [2:0]        state_q;
    reg               wr_q;
    reg               sem_q;
    reg               busy_meta_q;
    reg               busy_sync_q;
    reg               busy_prev_q;
    reg  [DATA_W-1:0] din_meta_q;
    reg  [DATA_W-1:0] din_sync_q;
    reg               tmr_load;
    reg  [3:0]        tmr_count;
    reg  [3:0]        wh_q;
    wire              tmr_done;
    wire              can_take;

    // ==========================================================
    // Timer
    cycle_timer #(
        .WIDTH (4)
    ) u_timer (
        .sys_clk (sys_clk),
        .reset   (reset),
        .load    (tmr_load),
        .count   (tmr_count),
        .done    (tmr_done)
    );

    // ==========================================================
    // Pin synchronisers
    // Busy and read data are asynchronous to sys_clk, so both pass two flops.
    always @(posedge sys_clk) begin
        if (reset) begin
            busy_meta_q <= 1'b1;
            busy_sync_q <= 1'b1;
            busy_prev_q <= 1'b1;
            din_meta_q  <= {DATA_W{1'b0}};
            din_sync_q  <= {DATA_W{1'b0}};
        end else begin
            busy_meta_q <= busy_n;                                // see R23
            busy_sync_q <= busy_meta_q;
            busy_prev_q <= busy_sync_q;
            din_meta_q  <= data_in;
            din_sync_q  <= din_meta_q;
        end
    end

    // ==========================================================
    // Busy release hold-off
    // Writes are held back after busy rises, for slave-mode parts.
    always @(posedge sys_clk) begin
        if (reset) begin
            wh_q <= 4'h0;
        end else if (busy_sync_q && !busy_prev_q) begin
            wh_q <= WH_CYC;                                       // see R14
        end else if (wh_q != 4'h0) begin
            wh_q <= wh_q - 4'h1;
        end
    end

    // ==========================================================
    // Request gate
    // Busy low, the cycle after its release and the hold-off all refuse new
    // requests; ready is the only promise, so the gate must act before it rises.
    assign can_take = !retain && busy_sync_q && busy_prev_q && (wh_q == 4'h0); // see R14, R16

    // ==========================================================
    // Timer load decode
    always @* begin
        tmr_load  = 1'b0;
        tmr_count = 4'h0;
        if (reset) begin
            tmr_load  = 1'b0;
        end else begin
            case (state_q)
                ST_PWRUP: begin
                    tmr_load  = !wr_q;
                    tmr_count = PWR_CYC;                          // see R17
                end
                ST_SETUP: begin
                    tmr_load  = 1'b1;
                    tmr_count = wr_q ? WR_CYC : RD_CYC;           // see R06
                end
                ST_WEND: begin
                    tmr_load  = 1'b1;
                    tmr_count = SOP_CYC;                          // see R10
                end
                default: begin
                    tmr_load  = 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Main sequencer
    // Every pin changes only on clock edges, one step per state, so select,
    // strobe and address never move together in a way that breaks ordering.
    always @(posedge sys_clk) begin
        if (reset) begin
            state_q             <= ST_PWRUP;
            wr_q                <= 1'b0;
            sem_q               <= 1'b0;
            req_ready           <= 1'b0;
            rsp_valid           <= 1'b0;
            rsp_rdata           <= {DATA_W{1'b0}};
            chip_select_n       <= 1'b1;                          // see R16
            semaphore_select_n  <= 1'b1;
            read_write_n        <= 1'b1;
            output_enable_n     <= 1'b1;
            upper_byte_enable_n <= 1'b1;
            addr                <= {ADDR_W{1'b0}};
            data_out            <= {DATA_W{1'b0}};
            data_oe             <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            case (state_q)
                ST_PWRUP: begin
                    // The first cycle loads the timer and marks itself in wr_q,
                    // so the wait is a full count longer than one read cycle.
                    wr_q <= 1'b1;
                    if (wr_q && tmr_done) begin                    // see R17
                        state_q   <= ST_IDLE;
                        req_ready <= can_take;
                    end
                end
                ST_IDLE: begin
                    chip_select_n      <= 1'b1;                   // see R16
                    semaphore_select_n <= 1'b1;
                    read_write_n       <= 1'b1;
                    req_ready          <= can_take;
                    if (req_valid && req_ready && !retain) begin
                        req_ready <= 1'b0;
                        wr_q      <= req_write;
                        sem_q     <= req_sem;
                        // Address moves only with read-not-write high and selects off.
                        addr <= req_sem ? {{(ADDR_W-`SEM_ADDR_BITS){1'b0}},
                                req_addr[`SEM_ADDR_BITS-1:0]} : req_addr; // see R03, R19
                        data_out <= req_sem ? {{(DATA_W-1){1'b0}}, req_wdata[0]} : req_wdata; // see R20
                        state_q  <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    // Read-not-write falls with the select, never after it, so
                    // the device keeps its outputs off and the data bus is ours.
                    chip_select_n       <= sem_q;                 // see R01, R08
                    semaphore_select_n  <= !sem_q;                // see R09
                    upper_byte_enable_n <= sem_q;
                    read_write_n        <= !wr_q;                 // see R02, R07
                    output_enable_n     <= wr_q;
                    data_oe             <= wr_q;
                    state_q             <= wr_q ? ST_WR : ST_RD;
                end
                ST_RD: begin
                    if (tmr_done) begin
                        rsp_rdata       <= din_sync_q;            // see R21, R15
                        rsp_valid       <= 1'b1;
                        chip_select_n      <= 1'b1;
                        semaphore_select_n <= 1'b1;
                        output_enable_n    <= 1'b1;
                        state_q         <= ST_GAP;
                    end
                end
                ST_WR: begin
                    if (tmr_done) begin
                        // Read-not-write rises first and ends the write.
                        read_write_n <= 1'b1;                     // see R04, R05
                        state_q      <= ST_WEND;
                    end
                end
                ST_WEND: begin
                    chip_select_n      <= 1'b1;
                    semaphore_select_n <= 1'b1;
                    data_oe            <= 1'b0;
                    rsp_valid          <= 1'b1;
                    state_q            <= sem_q ? ST_GAP : ST_IDLE;
                    req_ready          <= !sem_q && can_take;
                end
                ST_GAP: begin
                    // Selects stay high long enough for the semaphore flag update.
                    if (tmr_done || !sem_q || !wr_q) begin        // see R10, R11
                        state_q   <= ST_IDLE;
                        req_ready <= can_take;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // dpram_port_host

// ==== bench/dpram_host_props.sv ====
// Purpose: Pin protocol checker for the SRAM host controller.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to every controller instance.
// ====================
// Checker
module dpram_host_props #(parameter ADDR_W = 17, parameter DATA_W = 9) (
    // Clock, reset and user side.
    input logic              sys_clk,
    input logic              reset,
    input logic              retain,
    input logic              req_ready,
    // Memory port pins.
    input logic              chip_select_n,
    input logic              semaphore_select_n,
    input logic              read_write_n,
    input logic [ADDR_W-1:0] addr,
    input logic [DATA_W-1:0] data_out,
    input logic              data_oe,
    input logic              busy_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Either select low means the port is in a cycle.
    wire sel_low = !chip_select_n || !semaphore_select_n;
    sequence s_sem_rest; semaphore_select_n [*2]; endsequence
    // Two sync flops, one settle cycle and the hold-off keep writes off this long.
    sequence s_busy_rest; read_write_n [*7]; endsequence
    a_select_exclusive: assert property (chip_select_n || semaphore_select_n)
        else $error("Both selects low.");
    a_read_rw_high: assert property (sel_low && read_write_n |=> read_write_n || !sel_low)
        else $error("Read-not-write fell inside a read.");
    a_addr_rw_high: assert property (!$stable(addr) |-> read_write_n)
        else $error("Address moved during a write.");
    a_addr_before_sel: assert property ($rose(sel_low) |-> $stable(addr))
        else $error("Address moved as a select fell.");
    a_sem_addr_hold: assert property (!semaphore_select_n |-> $stable(addr))
        else $error("Semaphore read by address change.");
    a_sem_update_gap: assert property ($rose(semaphore_select_n) |-> s_sem_rest)
        else $error("Semaphore select back too soon.");
    a_write_data_drive: assert property (!read_write_n |-> data_oe && $stable(data_out))
        else $error("Write data not held through the pulse.");
    a_busy_rw_hold: assert property ($rose(busy_n) |-> s_busy_rest)
        else $error("Write too soon after busy release.");
    a_retain_refuse: assert property (retain |=> !req_ready)
        else $error("Request accepted in retention.");
    a_retain_deselect: assert property (retain [*8] |-> !sel_low)
        else $error("Select active in retention.");
    a_powerup_wait: assert property ($fell(reset) |-> (!req_ready && !sel_low) [*3])
        else $error("Access before the power-up wait.");
endmodule // dpram_host_props
bind dpram_port_host dpram_host_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_props (.*);

// ==== bench/sram_port_model.sv ====
// Purpose: Behavioural model of one SRAM port with eight semaphores.
// Assumes: Far port claims come from the bench.
// Notes: Released data lines show the inverse of the last value.
// ====================
// Port model
module sram_port_model #(parameter ACC_NS = 25) (
    // Host side pins.
    input  logic        chip_select_n,
    input  logic        semaphore_select_n,
    input  logic        read_write_n,
    input  logic        output_enable_n,
    input  logic [16:0] addr,
    input  logic [8:0]  data_out,
    input  logic        data_oe,
    // Semaphores held by the far port.
    input  logic [7:0]  other_own,
    // Resolved data lines.
    output logic [8:0]  data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [8:0] mem [0:131071];
    logic [8:0] rd_q, last_q = 9'h000;
    logic [7:0] mine = 8'h00;     // All semaphores start free.
    logic       sem_wr = 1'b0;
    wire wr_on = (!chip_select_n || !semaphore_select_n) && !read_write_n;
    wire rd_on = (chip_select_n != semaphore_select_n) && read_write_n && !output_enable_n;
    wire drv;
    // Data shows only after the access delay.
    assign #(ACC_NS) drv = rd_on;
    assign data_in = data_oe ? data_out : (drv ? rd_q : ~last_q);
    // Remember which target the write opened on.
    always @(posedge wr_on) sem_wr = !semaphore_select_n;
    // A write lands at the first rising select or read-not-write.
    always @(negedge wr_on) begin
        if (!sem_wr) mem[addr] = data_out;
        else mine[addr[2:0]] <= #5 !data_out[0] && (mine[addr[2:0]] || !other_own[addr[2:0]]);
    end
    // The read value is latched so a far write cannot change it mid-read.
    always @(posedge rd_on) rd_q = semaphore_select_n ? mem[addr] : {9{!mine[addr[2:0]]}};
    always @(negedge drv) last_q = rd_q;
endmodule // sram_port_model

// ==== bench/tb_dpram_port_host.sv ====
// Purpose: Self-checking bench for the SRAM host controller.
// Assumes: 10 MHz clock, reset held six cycles.
// Notes: Inputs change on the rising edge, outputs are read on the falling edge.
// ====================
// Bench top
`include "dpram_host_consts.vh"
module tb_dpram_port_host;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 0, reset = 1, req_valid = 0, req_write = 0, req_sem = 0, retain = 0, busy_n = 1;
    logic [16:0] req_addr = 17'h00000, addr;
    logic [8:0]  req_wdata = 9'h000, rsp_rdata, data_out, data_in;
    logic [7:0]  other_own = 8'h00;
    logic        req_ready, rsp_valid, chip_select_n, semaphore_select_n, read_write_n;
    logic        output_enable_n, upper_byte_enable_n, data_oe;
    int          n_mismatch = 0, num_checks = 0;
    dpram_port_host uut (.sys_clk(sys_clk), .reset(reset), .req_valid(req_valid), .req_write(req_write),
        .req_sem(req_sem), .req_addr(req_addr), .req_wdata(req_wdata), .retain(retain), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .chip_select_n(chip_select_n),
        .semaphore_select_n(semaphore_select_n), .read_write_n(read_write_n), .output_enable_n(output_enable_n),
        .upper_byte_enable_n(upper_byte_enable_n), .addr(addr), .data_out(data_out), .data_oe(data_oe),
        .data_in(data_in), .busy_n(busy_n));
    sram_port_model partner (.chip_select_n(chip_select_n), .semaphore_select_n(semaphore_select_n),
        .read_write_n(read_write_n), .output_enable_n(output_enable_n), .addr(addr), .data_out(data_out),
        .data_oe(data_oe), .other_own(other_own), .data_in(data_in));
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    // Compares for data words and single flags.
    task automatic check(input logic [8:0] exp, input logic [8:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic check_flag(input logic exp, input logic got);
        check({8'h00, exp}, {8'h00, got});
    endtask
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // One request: hold valid until taken, then wait for the answer.
    task automatic access(input logic w, s, input logic [16:0] a, input logic [8:0] d, output logic [8:0] q);
        int i;
        i = 0;
        @(posedge sys_clk);
        {req_valid, req_write, req_sem, req_addr, req_wdata} <= {1'b1, w, s, a, d};
        do begin @(negedge sys_clk); i++; end while (req_ready !== 1'b1 && i < 40);
        @(posedge sys_clk);
        req_valid <= 1'b0;
        do begin @(negedge sys_clk); i++; end while (rsp_valid !== 1'b1 && i < 80);
        if (i >= 80) begin
            n_mismatch++;
            finish_test();
        end else begin
            q = rsp_rdata;
        end
    endtask
    // Back-to-back array writes at both edges of the space and one mid-space address, then reads.
    task automatic test_array();
        logic [16:0] a [3] = '{17'h00000, 17'h1FFFF, 17'h0A5A5};
        logic [8:0]  d [3] = '{9'h1FF, 9'h000, 9'h15A};
        logic [8:0]  q;
        foreach (a[k]) access(1'b1, 1'b0, a[k], d[k], q);
        foreach (a[k]) begin
            access(1'b0, 1'b0, a[k], 9'h000, q);
            check(d[k], q);
        end
        $display("test_array done");
    endtask
    // Take, lose and release semaphores; high address bits are ignored.
    task automatic test_sem();
        logic [8:0] q;
        other_own <= 8'h20;
        access(1'b1, 1'b1, 17'h1FFF3, 9'h1FE, q);
        access(1'b0, 1'b1, 17'h00003, 9'h000, q);
        check(9'h000, q);
        access(1'b1, 1'b1, 17'h00005, 9'h000, q);
        access(1'b0, 1'b1, 17'h00005, 9'h000, q);
        check(9'h1FF, q);
        access(1'b1, 1'b1, 17'h00003, 9'h001, q);
        access(1'b0, 1'b1, 17'h1FFFB, 9'h000, q);
        check(9'h1FF, q);
        $display("test_sem done");
    endtask
    // Retention refuses requests and keeps both selects high.
    task automatic test_retain();
        @(posedge sys_clk);
        retain <= 1'b1;
        // A pending read must be refused for the whole retention time.
        @(posedge sys_clk);
        {req_valid, req_write, req_sem, req_addr} <= {1'b1, 1'b0, 1'b0, 17'h00000};
        repeat (10) @(negedge sys_clk);
        check_flag(1'b0, req_ready);
        check_flag(1'b1, chip_select_n & semaphore_select_n);
        @(posedge sys_clk);
        {retain, req_valid} <= 2'b00;
        $display("test_retain done");
    endtask
    // A write straight after the contention flag is released.
    task automatic test_busy();
        logic [8:0] q;
        @(posedge sys_clk);
        busy_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        check_flag(1'b0, req_ready);
        @(posedge sys_clk);
        busy_n <= 1'b1;
        access(1'b1, 1'b0, 17'h00123, 9'h0C3, q);
        access(1'b0, 1'b0, 17'h00123, 9'h000, q);
        check(9'h0C3, q);
        $display("test_busy done");
    endtask
    // Reset in mid-run, then the power-up wait before any access.
    task automatic test_reset();
        logic [8:0] q;
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        // Ready stays low through the power-up count and rises one cycle after it.
        repeat (`PWR_WAIT_CYC) @(posedge sys_clk);
        @(negedge sys_clk);
        check_flag(1'b0, req_ready);
        @(negedge sys_clk);
        check_flag(1'b1, req_ready);
        access(1'b0, 1'b0, 17'h1FFFF, 9'h000, q);
        check(9'h000, q);
        $display("test_reset done");
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        test_array();
        test_sem();
        test_retain();
        test_busy();
        test_reset();
        finish_test();
    end
endmodule // tb_dpram_port_host
